/* rte_regs.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef RTE_REGS_VH
`define RTE_REGS_VH
// Register offsets, byte addresses on the register port
`define RTE_OFS_MODE 8'h00
`define RTE_OFS_ADC_MODE 8'h04
`define RTE_OFS_CHARGE 8'h08
`define RTE_OFS_SETTLE 8'h0c
`define RTE_OFS_OVERSAMPLE 8'h10
`define RTE_OFS_RZTHRESH 8'h14
`define RTE_OFS_RAW 8'h18
`define RTE_OFS_SCREEN 8'h1c
`define RTE_OFS_TAG 8'h20
`define RTE_OFS_TAG_POS 8'h24
`define RTE_OFS_RZ 8'h28
`define RTE_OFS_DIRECT_POS 8'h2c
`define RTE_OFS_DIRECT_Z 8'h30
`define RTE_OFS_MAT_A 8'h34
// Sampling modes
`define RTE_MODE_STOPPED 2'h0
`define RTE_MODE_SINGLE 2'h1
`define RTE_MODE_FRAME 2'h2
`define RTE_MODE_CONT 2'h3
// Reset values
`define RTE_RST_CHARGE 16'h0bb8
`define RTE_RST_SETTLE 4'h3
`define RTE_RST_OVERSAMPLE 4'h7
`define RTE_RST_RZTHRESH 16'hffff
`define RTE_RST_MAT_ONE 32'h00010000
// Not-pressed values
`define RTE_RAW_NONE 32'hffffffff
`define RTE_SCR_NONE 32'h80008000
`define RTE_RZ_NONE 16'h7fff
// Direct register fields
`define RTE_DIR_FLAG 31
`define RTE_DIR_HI_MSB 25
`define RTE_DIR_HI_LSB 16
// One charge unit is 100 ns
`define RTE_CHARGE_UNIT_NS 100
`define RTE_CLK_PERIOD_NS 5
`define RTE_CHARGE_CYC (`RTE_CHARGE_UNIT_NS / `RTE_CLK_PERIOD_NS)
// One settle unit is 20 charge-units of clock
`define RTE_SETTLE_CYC 16'h0190
`endif

/* rte_touch_engine.v */
// Resistive touch sensing engine with register port
// Summary of operation
// R1: Raw x and y positions within 0..1023 are reported in raw position register.
// R2: Raw position register reads 0xFFFF per half while not pressed.
// R3: Six written coefficients transform raw positions into screen position register.
// R4: Screen position register holds 0x8000 per half while not pressed.
// R5: While touched, screen point is looked up, 8-bit tag stored.
// R6: Coordinates used for the tag lookup are kept in tag position register.
// R7: Pressure register spans 0 firmest to 32767 with no touch.
// R8: Modes: continuous, single per write, once per frame, stopped.
// R9: ADC mode selects single-ended or differential conversion.
// R10: Panel driven for charge time before pen detect; default 3000 is 0.3ms.
// R11: No touch reported when resistance exceeds threshold, default 65535.
// R12: Panel driven for settle time before each position sample.
// R13: Oversampling factor sets how many samples are averaged.
// R14: Each 32-bit result register updates whole in one cycle.
// R15: Conversion-done pulse after all result registers are updated; tag and tag position registers update later, on the next frame.
// R16: Direct 10-bit ADC values in two registers with flag bit 31.
// R17: Direct flag is 0 with valid touch, 1 when no touch.
// R18: First direct value in bits 25..16, second in bits 9..0.
`timescale 1ns/1ps
`default_nettype none
`include "rte_regs.vh"
module rte_touch_engine (
	input wire i_clk,
	input wire i_rst,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	output reg [31:0] o_rdata,
	output reg o_rvalid,
	input wire i_frame_start,
	output reg o_panel_drive,
	output reg [1:0] o_adc_chan,
	output reg o_adc_diff,
	output reg o_adc_start,
	input wire i_adc_done,
	input wire [9:0] i_adc_data,
	input wire i_pen_detect,
	output reg o_tag_req,
	output reg [31:0] o_tag_xy,
	input wire i_tag_ack,
	input wire [7:0] i_tag_value,
	output reg o_conversion_done_irq
);
	// Phase codes of the sensing sequencer
	localparam ST_IDLE = 3'h0;
	localparam ST_CHARGE = 3'h1;
	localparam ST_SETTLE = 3'h2;
	localparam ST_CONV = 3'h3;
	localparam ST_WAIT = 3'h4;
	localparam ST_CALC = 3'h5;
	localparam ST_PUBLISH = 3'h6;
	reg [1:0] mode;
	reg adc_mode;
	reg [15:0] charge;
	reg [3:0] settle;
	reg [3:0] oversample;
	reg [15:0] rzthresh;
	reg [31:0] mat [0:5];
	reg [31:0] raw_position_reg;
	reg [31:0] screen_position_reg;
	reg [7:0] tag;
	reg [31:0] tag_lookup_position;
	reg [15:0] press_resistance_reg;
	reg [31:0] touch_direct_position;
	reg [31:0] touch_direct_pressure_pair;
	reg single_pend;
	reg [2:0] state;
	reg [31:0] cnt;
	reg [1:0] chan;
	reg [3:0] nsamp;
	reg [13:0] acc;
	reg [9:0] val [0:3];
	reg pen_s1, pen_s2;
	reg done_s1, done_s2;
	reg [9:0] dat_s1, dat_s2;
	reg done_q;
	reg tag_busy;
	reg [31:0] sx, sy;
	reg [15:0] rz_calc;
	integer k;
	integer j;
	wire adc_event;
	wire touched;
	assign adc_event = done_s2 & ~done_q;
	assign touched = pen_s2 & (rz_calc <= rzthresh);

	// Signed fixed-point transform of one axis, 16.16 coefficients
	function [15:0] rte_xform;
		input [31:0] ca, cb, cc;
		input [9:0] rx, ry;
		reg signed [47:0] s;
		begin
			s = $signed(ca) * $signed({6'h00, rx});
			s = s + $signed(cb) * $signed({6'h00, ry});
			s = s + $signed({{16{cc[31]}}, cc});
			rte_xform = s[31:16];
		end
	endfunction

	// Settle count in clocks; fifteen units still fit in sixteen bits
	function [31:0] rte_settle_cycles;
		input [3:0] units;
		reg [15:0] prod;
		begin
			prod = units * `RTE_SETTLE_CYC;
			rte_settle_cycles = {16'h0000, prod};
		end
	endfunction

	// Mean of oversample+1 readings; the quotient never needs over ten bits
	function [9:0] rte_average;
		input [13:0] sum;
		input [9:0] last;
		input [3:0] extra;
		reg [13:0] quot;
		begin
			quot = (sum + {4'h0, last}) / ({10'h000, extra} + 14'h0001);
			rte_average = quot[9:0];
		end
	endfunction

	// Pins from the panel front end pass two flops
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pen_s1 <= 1'b0;
			pen_s2 <= 1'b0;
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			dat_s1 <= 10'h000;
			dat_s2 <= 10'h000;
			done_q <= 1'b0;
		end else begin
			pen_s1 <= i_pen_detect;
			pen_s2 <= pen_s1;
			done_s1 <= i_adc_done;
			done_s2 <= done_s1;
			dat_s1 <= i_adc_data;
			dat_s2 <= dat_s1;
			done_q <= done_s2;
		end
	end

	// Resistance estimate from x, z1, z2; no-touch value when z1 is zero or z2 is below z1
	always @* begin
		rz_calc = `RTE_RZ_NONE;
		if (val[2] != 10'h000 && val[3] >= val[2]) begin
			rz_calc = {2'h0, val[0][9:6], (val[3] - val[2])};
		end
	end

	// Register port and configuration; writes steer the sequencer
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode <= `RTE_MODE_STOPPED;
			adc_mode <= 1'b0;
			charge <= `RTE_RST_CHARGE;
			settle <= `RTE_RST_SETTLE;
			oversample <= `RTE_RST_OVERSAMPLE;
			rzthresh <= `RTE_RST_RZTHRESH;
			for (k = 0; k < 6; k = k + 1) begin
				mat[k] <= (k == 0 || k == 4) ? `RTE_RST_MAT_ONE : 32'h0;
			end
			o_rdata <= 32'h00000000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd;
			if (i_wr) begin
				case (i_addr)
				`RTE_OFS_MODE: mode <= i_wdata[1:0]; // [R8]
				`RTE_OFS_ADC_MODE: adc_mode <= i_wdata[0]; // [R9]
				`RTE_OFS_CHARGE: charge <= i_wdata[15:0]; // [R10]
				`RTE_OFS_SETTLE: settle <= i_wdata[3:0]; // [R12]
				`RTE_OFS_OVERSAMPLE: oversample <= i_wdata[3:0]; // [R13]
				`RTE_OFS_RZTHRESH: rzthresh <= i_wdata[15:0]; // [R11]
				default: begin
					for (k = 0; k < 6; k = k + 1) begin
						if (i_addr == `RTE_OFS_MAT_A + k[7:0] * 8'h04)
							mat[k] <= i_wdata; // [R3]
					end
				end
				endcase
			end
			if (i_rd) begin
				case (i_addr)
				`RTE_OFS_MODE: o_rdata <= {30'h0, mode};
				`RTE_OFS_ADC_MODE: o_rdata <= {31'h0, adc_mode};
				`RTE_OFS_CHARGE: o_rdata <= {16'h0, charge};
				`RTE_OFS_SETTLE: o_rdata <= {28'h0, settle};
				`RTE_OFS_OVERSAMPLE: o_rdata <= {28'h0, oversample};
				`RTE_OFS_RZTHRESH: o_rdata <= {16'h0, rzthresh};
				`RTE_OFS_RAW: o_rdata <= raw_position_reg; // [R1]
				`RTE_OFS_SCREEN: o_rdata <= screen_position_reg;
				`RTE_OFS_TAG: o_rdata <= {24'h0, tag};
				`RTE_OFS_TAG_POS: o_rdata <= tag_lookup_position;
				`RTE_OFS_RZ: o_rdata <= {16'h0, press_resistance_reg};
				`RTE_OFS_DIRECT_POS: o_rdata <= touch_direct_position;
				`RTE_OFS_DIRECT_Z: o_rdata <= touch_direct_pressure_pair;
				default: begin
					o_rdata <= 32'h00000000; // Unmapped reads zero
					for (k = 0; k < 6; k = k + 1) begin
						if (i_addr == `RTE_OFS_MAT_A + k[7:0] * 8'h04)
							o_rdata <= mat[k];
					end
				end
				endcase
			end
		end
	end

	// Sensing sequencer: charge, settle, convert, accumulate, publish
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			cnt <= 32'h0;
			chan <= 2'h0;
			nsamp <= 4'h0;
			acc <= 14'h0;
			single_pend <= 1'b0;
			for (j = 0; j < 4; j = j + 1) val[j] <= 10'h000;
			sx <= 32'h0;
			sy <= 32'h0;
			o_panel_drive <= 1'b0;
			o_adc_chan <= 2'h0;
			o_adc_diff <= 1'b0;
			o_adc_start <= 1'b0;
			raw_position_reg <= `RTE_RAW_NONE;
			screen_position_reg <= `RTE_SCR_NONE;
			press_resistance_reg <= `RTE_RZ_NONE;
			touch_direct_position <= 32'h80000000;
			touch_direct_pressure_pair <= 32'h80000000;
			o_conversion_done_irq <= 1'b0;
		end else begin
			o_adc_start <= 1'b0;
			o_conversion_done_irq <= 1'b0;
			o_adc_diff <= adc_mode; // [R9]
			// A write of single mode arms one sample
			if (i_wr && i_addr == `RTE_OFS_MODE &&
			    i_wdata[1:0] == `RTE_MODE_SINGLE)
				single_pend <= 1'b1; // [R8]
			case (state)
			ST_IDLE: begin
				o_panel_drive <= 1'b0;
				if (mode == `RTE_MODE_CONT || single_pend ||
				    (mode == `RTE_MODE_FRAME && i_frame_start)) begin // [R8]
					if (!(i_wr && i_addr == `RTE_OFS_MODE))
						single_pend <= 1'b0;
					o_panel_drive <= 1'b1;
					cnt <= charge * `RTE_CHARGE_CYC; // [R10]
					state <= ST_CHARGE;
				end
			end
			ST_CHARGE: begin
				if (cnt > 32'h1) begin
					cnt <= cnt - 32'h1;
				end else begin
					chan <= 2'h0;
					cnt <= rte_settle_cycles(settle); // [R12]
					state <= ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (cnt > 32'h1) begin
					cnt <= cnt - 32'h1;
				end else begin
					nsamp <= 4'h0;
					acc <= 14'h0;
					state <= ST_CONV;
				end
			end
			ST_CONV: begin
				o_adc_chan <= chan;
				o_adc_start <= 1'b1;
				state <= ST_WAIT;
			end
			ST_WAIT: begin
				if (adc_event) begin
					// Average over oversample+1 readings
					if (nsamp == oversample) begin // [R13]
						val[chan] <= rte_average(acc, dat_s2, oversample);
						if (chan == 2'h3) begin
							state <= ST_CALC;
						end else begin
							chan <= chan + 2'h1;
							cnt <= rte_settle_cycles(settle); // [R12]
							state <= ST_SETTLE;
						end
					end else begin
						acc <= acc + {4'h0, dat_s2};
						nsamp <= nsamp + 4'h1;
						state <= ST_CONV;
					end
				end
			end
			ST_CALC: begin
				o_panel_drive <= 1'b0;
				sx <= {16'h0, rte_xform(mat[0], mat[1], mat[2],
				                        val[0], val[1])}; // [R3]
				sy <= {16'h0, rte_xform(mat[3], mat[4], mat[5],
				                        val[0], val[1])};
				state <= ST_PUBLISH;
			end
			ST_PUBLISH: begin
				// Results change in one cycle; with no touch the direct words only set their flag bit
				if (touched) begin // [R11]
					raw_position_reg <= {6'h0, val[0], 6'h0, val[1]}; // [R1] [R14]
					screen_position_reg <= {sx[15:0], sy[15:0]}; // [R3] [R14]
					press_resistance_reg <= rz_calc; // [R7]
					touch_direct_position <= {6'h00, val[0], 6'h00,
					                          val[1]}; // [R16] [R17] [R18]
					touch_direct_pressure_pair <= {6'h00, val[2], 6'h00,
					                               val[3]}; // [R16] [R18]
				end else begin
					raw_position_reg <= `RTE_RAW_NONE; // [R2]
					screen_position_reg <= `RTE_SCR_NONE; // [R4]
					press_resistance_reg <= `RTE_RZ_NONE; // [R7]
					touch_direct_position[`RTE_DIR_FLAG] <= 1'b1; // [R17]
					touch_direct_pressure_pair[`RTE_DIR_FLAG] <= 1'b1;
				end
				o_conversion_done_irq <= 1'b1; // [R15]
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Tag lookup spans a frame; coordinates used are latched with it
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tag_busy <= 1'b0;
			o_tag_req <= 1'b0;
			o_tag_xy <= `RTE_SCR_NONE;
			tag_lookup_position <= `RTE_SCR_NONE;
			tag <= 8'h00;
		end else begin
			o_tag_req <= 1'b0;
			if (!tag_busy && i_frame_start &&
			    screen_position_reg != `RTE_SCR_NONE) begin // [R5]
				tag_busy <= 1'b1;
				o_tag_req <= 1'b1;
				o_tag_xy <= screen_position_reg;
			end else if (tag_busy && i_tag_ack) begin
				tag_busy <= 1'b0;
				tag <= i_tag_value; // [R5]
				tag_lookup_position <= o_tag_xy; // [R6] [R14]
			end
		end
	end
endmodule // rte_touch_engine
`default_nettype wire

/* rte_panel_model.sv */
// Panel, ADC front end and tag buffer model for the touch engine
`timescale 1ns/1ps
`default_nettype none
module rte_panel_model (
	input wire logic i_clk,
	input wire logic i_touch,
	input wire logic i_panel_drive,
	input wire logic i_adc_start,
	input wire logic [1:0] i_adc_chan,
	input wire logic i_tag_req,
	output logic o_adc_done,
	output logic [9:0] o_adc_data,
	output logic o_pen_detect,
	output logic o_tag_ack,
	output logic [7:0] o_tag_value
);
	logic [9:0] tbl [4] = '{10'h155, 10'h2aa, 10'h040, 10'h080};
	logic [9:0] val;
	int lat = 3;
	// Pen line only reads back while the panel is powered
	assign o_pen_detect = i_touch & i_panel_drive;
	// One conversion per start, latency alternates prompt and slow
	initial begin
		o_adc_done = 1'b0;
		o_adc_data = 10'h3ff;
		forever begin
			@(posedge i_clk);
			if (i_adc_start) begin
				val = tbl[i_adc_chan];
				repeat (lat) @(posedge i_clk);
				o_adc_data <= val;
				o_adc_done <= 1'b1;
				repeat (4) @(posedge i_clk);
				o_adc_done <= 1'b0;
				o_adc_data <= ~val; // Stale data is not left on the bus
				lat = (lat == 3) ? 20 : 3;
			end
		end
	end
	// Tag buffer answers a lookup a few cycles later
	initial begin
		o_tag_ack = 1'b0;
		o_tag_value = 8'h00;
		forever begin
			@(posedge i_clk);
			if (i_tag_req) begin
				repeat (5) @(posedge i_clk);
				o_tag_value <= 8'h5a;
				o_tag_ack <= 1'b1;
				@(posedge i_clk);
				o_tag_ack <= 1'b0;
				o_tag_value <= 8'ha5;
			end
		end
	end
endmodule // rte_panel_model
`default_nettype wire

/* rte_touch_asserts.sv */
// Port checker for the resistive touch engine
`timescale 1ns/1ps
`default_nettype none
`include "rte_regs.vh"
module rte_touch_asserts (
	input wire i_clk,
	input wire i_rst,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire [31:0] o_rdata,
	input wire o_rvalid,
	input wire o_panel_drive,
	input wire o_adc_diff,
	input wire o_adc_start,
	input wire o_tag_req,
	input wire o_conversion_done_irq
);
	logic diff_cfg;
	// Shadow of the ADC mode bit, so each conversion can be judged
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			diff_cfg <= 1'b0;
		else if (i_wr && i_addr == `RTE_OFS_ADC_MODE)
			diff_cfg <= i_wdata[0];
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	rd_answer_a: assert property (i_rd |=> o_rvalid) else $error("read not answered");
	rvalid_cause_a: assert property (o_rvalid |-> $past(i_rd))
		else $error("read valid without read");
	unmapped_zero_a: assert property (i_rd && i_addr == 8'hfc |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	settle_drive_a: assert property (o_adc_start |-> o_panel_drive)
		else $error("sample taken with panel undriven");
	charge_gap_a: assert property ($rose(o_panel_drive) |=> !o_adc_start [*8])
		else $error("sample too soon after drive");
	irq_pulse_a: assert property (o_conversion_done_irq |=> !o_conversion_done_irq)
		else $error("done pulse too long");
	tag_pulse_a: assert property (o_tag_req |=> !o_tag_req [*2])
		else $error("tag request repeated");
	adc_mode_a: assert property (o_adc_start |-> o_adc_diff == diff_cfg)
		else $error("adc mode mismatch");
endmodule // rte_touch_asserts
bind rte_touch_engine rte_touch_asserts i_rte_touch_asserts (.i_clk(i_clk),
	.i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
	.i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
	.o_panel_drive(o_panel_drive), .o_adc_diff(o_adc_diff),
	.o_adc_start(o_adc_start), .o_tag_req(o_tag_req),
	.o_conversion_done_irq(o_conversion_done_irq));
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the resistive touch engine
`timescale 1ns/1ps
`default_nettype none
`include "rte_regs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
	logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_frame_start = 0, touch = 1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	int err_total = 0, compares = 0, irq_cnt = 0, n;
	wire [31:0] o_rdata, o_tag_xy;
	wire o_rvalid, o_panel_drive, o_adc_diff, o_adc_start, o_tag_req, irq;
	wire [1:0] o_adc_chan;
	wire adc_done, pen, tag_ack;
	wire [9:0] adc_data;
	wire [7:0] tag_value;
	// Reset-value table: address beside expected read data
	logic [39:0] rows [12] = '{{`RTE_OFS_CHARGE, 16'h0, `RTE_RST_CHARGE},
		{`RTE_OFS_SETTLE, 28'h0, `RTE_RST_SETTLE},
		{`RTE_OFS_OVERSAMPLE, 28'h0, `RTE_RST_OVERSAMPLE},
		{`RTE_OFS_RZTHRESH, 16'h0, `RTE_RST_RZTHRESH},
		{`RTE_OFS_RAW, 32'hffffffff}, {`RTE_OFS_SCREEN, 32'h80008000},
		{`RTE_OFS_RZ, 32'h00007fff}, {`RTE_OFS_DIRECT_POS, 32'h80000000},
		{`RTE_OFS_DIRECT_Z, 32'h80000000}, {`RTE_OFS_MAT_A, 32'h00010000},
		{8'h44, 32'h00010000}, {8'hfc, 32'h0}};
	always #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) if (irq === 1'b1) irq_cnt++;
	rte_touch_engine i_rte_touch_engine (.i_clk(i_clk), .i_rst(i_rst),
		.i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_frame_start(i_frame_start),
		.o_panel_drive(o_panel_drive), .o_adc_chan(o_adc_chan),
		.o_adc_diff(o_adc_diff), .o_adc_start(o_adc_start),
		.i_adc_done(adc_done), .i_adc_data(adc_data), .i_pen_detect(pen),
		.o_tag_req(o_tag_req), .o_tag_xy(o_tag_xy), .i_tag_ack(tag_ack),
		.i_tag_value(tag_value), .o_conversion_done_irq(irq));
	rte_panel_model i_rte_panel_model (.i_clk(i_clk), .i_touch(touch),
		.i_panel_drive(o_panel_drive), .i_adc_start(o_adc_start),
		.i_adc_chan(o_adc_chan), .i_tag_req(o_tag_req), .o_adc_done(adc_done),
		.o_adc_data(adc_data), .o_pen_detect(pen), .o_tag_ack(tag_ack),
		.o_tag_value(tag_value));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge i_clk);
		i_wr = 1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
		i_wr = 0;
	endtask
	// Read answers one cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
		@(negedge i_clk);
		i_rd = 1;
		i_addr = a;
		@(negedge i_clk);
		i_rd = 0;
		`CHK("read valid", 1'b1, o_rvalid)
		`CHK(s, e, o_rdata)
	endtask
	// Bounded wait for the end of a sensing cycle
	task automatic wait_irq;
		int k;
		// At least one edge first, so a pulse already seen is not counted twice
		for (k = 0; k < 6000; k++) begin
			@(posedge i_clk);
			#1;
			if (irq === 1'b1) break;
		end
		`CHK("done pulse", 1'b1, irq)
		@(negedge i_clk);
	endtask
	task automatic frame;
		@(negedge i_clk);
		i_frame_start = 1;
		@(negedge i_clk);
		i_frame_start = 0;
	endtask
	task end_sim;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// About 50k clocks, well beyond the roughly 20k the tests need
	initial begin
		#250000;
		err_total++;
		end_sim;
	end
	initial begin
		repeat (8) @(negedge i_clk);
		i_rst = 0;
		for (int r = 0; r < 12; r++) rchk(rows[r][39:32], rows[r][31:0], "reset");
		// Short timings so a cycle takes about two thousand clocks
		wr(`RTE_OFS_CHARGE, 32'h1);
		wr(`RTE_OFS_SETTLE, 32'h1);
		wr(`RTE_OFS_OVERSAMPLE, 32'h1);
		wr(`RTE_OFS_MODE, {30'h0, `RTE_MODE_SINGLE});
		wait_irq;
		rchk(`RTE_OFS_RAW, 32'h015502aa, "raw");
		rchk(`RTE_OFS_SCREEN, 32'h015502aa, "screen");
		rchk(`RTE_OFS_RZ, 32'h00001440, "rz");
		rchk(`RTE_OFS_DIRECT_POS, 32'h015502aa, "direct xy");
		rchk(`RTE_OFS_DIRECT_Z, 32'h00400080, "direct z");
		// Tag lookup launched by the next frame
		frame;
		repeat (20) @(negedge i_clk);
		rchk(`RTE_OFS_TAG, 32'h0000005a, "tag");
		rchk(`RTE_OFS_TAG_POS, 32'h015502aa, "tag pos");
		`CHK("tag xy", 32'h015502aa, o_tag_xy)
		// Threshold below the estimate hides the touch
		wr(`RTE_OFS_RZTHRESH, 32'h1000);
		wr(`RTE_OFS_MODE, {30'h0, `RTE_MODE_SINGLE});
		wait_irq;
		rchk(`RTE_OFS_RAW, 32'hffffffff, "raw gated");
		rchk(`RTE_OFS_SCREEN, 32'h80008000, "screen gated");
		// Pen lifted: flag set, old fields kept
		touch = 0;
		wr(`RTE_OFS_RZTHRESH, 32'h0000ffff);
		wr(`RTE_OFS_MODE, {30'h0, `RTE_MODE_SINGLE});
		wait_irq;
		rchk(`RTE_OFS_RZ, 32'h00007fff, "rz lifted");
		rchk(`RTE_OFS_DIRECT_POS, 32'h815502aa, "direct lifted");
		// Differential conversions, once per frame
		touch = 1;
		wr(`RTE_OFS_ADC_MODE, 32'h1);
		wr(`RTE_OFS_MODE, {30'h0, `RTE_MODE_FRAME});
		frame;
		wait_irq;
		// Continuous runs on its own, then stopping silences it
		wr(`RTE_OFS_MODE, {30'h0, `RTE_MODE_CONT});
		wait_irq;
		wait_irq;
		wr(`RTE_OFS_MODE, {30'h0, `RTE_MODE_STOPPED});
		repeat (2500) @(negedge i_clk);
		n = irq_cnt;
		repeat (3000) @(negedge i_clk);
		`CHK("stopped cycles", n, irq_cnt)
		// Reset while stopped drops held results back to their idle values
		@(negedge i_clk);
		i_rst = 1;
		repeat (2) @(negedge i_clk);
		i_rst = 0;
		rchk(`RTE_OFS_RAW, 32'hffffffff, "raw after reset");
		rchk(`RTE_OFS_MODE, 32'h0, "mode after reset");
		end_sim;
	end
endmodule // testbench
`default_nettype wire
